// *** core/seq_timing_map.vh ***
// timing and register constants for the sensor power sequencer
// assumes a 50 MHz system clock (20 ns period)
`ifndef SEQ_TIMING_MAP_VH
`define SEQ_TIMING_MAP_VH

`define CLK_PERIOD_NS 20
`define RAIL_GAP_US 10
`define RAIL_GAP_CYC ((`RAIL_GAP_US * 1000) / `CLK_PERIOD_NS)
`define RESET_HOLD_MS 1
`define RESET_HOLD_CYC ((`RESET_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
`define INIT_REF_CYCLES 850000
`define PLL_LOCK_MS 1
`define PLL_LOCK_CYC ((`PLL_LOCK_MS * 1000000) / `CLK_PERIOD_NS)
`define OFF_GAP_MS 100
`define OFF_GAP_CYC ((`OFF_GAP_MS * 1000000) / `CLK_PERIOD_NS)
`define REF_CLK_DIV 4
`define RESET_CTRL_ADDR 16'h301A
`define STREAM_BIT 2
`define STANDBY_TIMEOUT_CYC 200000

`endif

// *** core/pin_sync3.v ***
// three-stage synchroniser for one pin input
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
    input wire sys_clk,
    input wire rst,
    input wire pin_in,
    output reg level
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    always @(posedge sys_clk) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // change counts once stages two and three agree
            if (s2_ff == s3_ff)
                level <= s3_ff;
        end
    end
endmodule
`default_nettype wire

// *** core/ref_clk_div.v ***
// divider driving the reference clock pin and a one-cycle edge enable
// assumes sys_clk is the only clock
`timescale 1ns/100ps
`default_nettype none
`include "seq_timing_map.vh"
module ref_clk_div (
    input wire sys_clk,
    input wire rst,
    input wire run,
    output reg ref_clk_out,
    output reg ref_rise
);
    reg [7:0] cnt_ff;
    always @(posedge sys_clk) begin
        if (rst || !run) begin
            cnt_ff <= 8'h00;
            ref_clk_out <= 1'b0;
            ref_rise <= 1'b0;
        end else begin
            ref_rise <= 1'b0;
            if (cnt_ff == `REF_CLK_DIV / 2 - 1) begin
                cnt_ff <= 8'h00;
                ref_clk_out <= ~ref_clk_out;
                ref_rise <= ~ref_clk_out;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/sensor_power_sequencer.v ***
// host-side power sequencer for an image sensor: rails, clock, reset, stream
// assumes power-good pins are asynchronous; register writes go out through
// a simple write-request port handled by an external serial master
`timescale 1ns/100ps
`default_nettype none
`include "seq_timing_map.vh"
module sensor_power_sequencer #(
    parameter RESET_HOLD_CYC = `RESET_HOLD_CYC,
    parameter INIT_REF_CYCLES = `INIT_REF_CYCLES,
    parameter PLL_LOCK_CYC = `PLL_LOCK_CYC,
    parameter OFF_GAP_CYC = `OFF_GAP_CYC,
    parameter STANDBY_TIMEOUT_CYC = `STANDBY_TIMEOUT_CYC
) (
    input wire sys_clk,
    input wire rst,
    input wire power_up_req,
    input wire power_down_req,
    input wire abort_req,
    input wire cfg_done,
    input wire stream_req,
    input wire use_pgood,
    input wire pll_pgood_pin,
    input wire analog_pgood_pin,
    input wire io_pgood_pin,
    input wire core_pgood_pin,
    input wire standby_pin,
    input wire wr_ready,
    output reg pll_rail_en,
    output reg analog_supply_rail_en,
    output reg pixel_supply_rail_en,
    output reg io_rail_en,
    output reg core_rail_en,
    output wire reference_clock_input,
    output reg sensor_reset_n,
    output wire wr_valid,
    output reg [15:0] wr_addr,
    output reg [15:0] wr_data,
    output reg ready_for_config,
    output reg streaming,
    output reg busy,
    output reg fault
);
    localparam [4:0] S_OFF = 5'd0, S_PLL = 5'd1, S_ANA = 5'd2, S_IO = 5'd3;
    localparam [4:0] S_CORE = 5'd4, S_STABLE = 5'd5, S_RESET = 5'd6;
    localparam [4:0] S_INIT = 5'd7, S_CONFIG = 5'd8, S_LOCK = 5'd9;
    localparam [4:0] S_WR_ON = 5'd10, S_STREAM = 5'd11, S_WR_OFF = 5'd12;
    localparam [4:0] S_WAIT_SB = 5'd13, S_DN_CORE = 5'd14, S_DN_IO = 5'd15;
    localparam [4:0] S_DN_ANA = 5'd16, S_DN_PLL = 5'd17, S_GAP = 5'd18;
    localparam [31:0] GAP_CYC = `RAIL_GAP_CYC;

    reg [4:0] state_ff;
    reg [31:0] cnt_ff;
    reg wr_pend_ff;
    reg clk_run_ff;
    wire pll_pg;
    wire ana_pg;
    wire io_pg;
    wire core_pg;
    wire standby_s;
    wire ref_rise;
    wire sb_done;
    wire dn_start;
    wire abort_go;
    wire clk_stop;

    pin_sync3 u_sync_pll (.sys_clk(sys_clk), .rst(rst), .pin_in(pll_pgood_pin),
        .level(pll_pg));
    pin_sync3 u_sync_ana (.sys_clk(sys_clk), .rst(rst), .pin_in(analog_pgood_pin),
        .level(ana_pg));
    pin_sync3 u_sync_io (.sys_clk(sys_clk), .rst(rst), .pin_in(io_pgood_pin),
        .level(io_pg));
    pin_sync3 u_sync_core (.sys_clk(sys_clk), .rst(rst), .pin_in(core_pgood_pin),
        .level(core_pg));
    pin_sync3 u_sync_sb (.sys_clk(sys_clk), .rst(rst), .pin_in(standby_pin),
        .level(standby_s));

    ref_clk_div u_div (.sys_clk(sys_clk), .rst(rst), .run(clk_run_ff && !clk_stop),
        .ref_clk_out(reference_clock_input), .ref_rise(ref_rise));

    assign wr_valid = wr_pend_ff;

    // shared end test of the cycle counters
    function cnt_done;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            cnt_done = (cnt >= lim - 32'd1);
        end
    endfunction

    // a rail step may advance on power-good or, if unused, on the timer
    function step_ok;
        input pg;
        input pg_mode;
        input [31:0] cnt;
        begin
            step_ok = pg_mode ? pg : cnt_done(cnt, GAP_CYC);
        end
    endfunction

    assign abort_go = abort_req && (state_ff != S_OFF) && (state_ff != S_GAP);
    // standby seen or wait timed out
    assign sb_done = standby_s || cnt_done(cnt_ff, STANDBY_TIMEOUT_CYC);
    // leave standby wait for rail removal
    assign dn_start = (state_ff == S_WAIT_SB) && sb_done &&
        (power_down_req || !ready_for_config);
    // clock stop term
    // the divider sees clk_run_ff one edge late; without this it could raise
    // the clock pin in the very edge that removes the rails
    assign clk_stop = abort_go || dn_start;

    always @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= S_OFF;
            cnt_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            clk_run_ff <= 1'b0;
            pll_rail_en <= 1'b0;
            analog_supply_rail_en <= 1'b0;
            pixel_supply_rail_en <= 1'b0;
            io_rail_en <= 1'b0;
            core_rail_en <= 1'b0;
            sensor_reset_n <= 1'b0;
            wr_addr <= 16'h0000;
            wr_data <= 16'h0000;
            ready_for_config <= 1'b0;
            streaming <= 1'b0;
            busy <= 1'b0;
            fault <= 1'b0;
        end else if (abort_go) begin
            pll_rail_en <= 1'b0;
            analog_supply_rail_en <= 1'b0;
            pixel_supply_rail_en <= 1'b0;
            io_rail_en <= 1'b0;
            core_rail_en <= 1'b0;
            clk_run_ff <= 1'b0;
            sensor_reset_n <= 1'b0;
            wr_pend_ff <= 1'b0;
            ready_for_config <= 1'b0;
            streaming <= 1'b0;
            busy <= 1'b1;
            cnt_ff <= 32'h0000_0000;
            state_ff <= S_GAP;
        end else begin
            cnt_ff <= cnt_ff + 32'd1;
            if (wr_pend_ff && wr_ready)
                wr_pend_ff <= 1'b0;
            case (state_ff)
                S_OFF: begin
                    busy <= 1'b0;
                    if (power_up_req) begin
                        pll_rail_en <= 1'b1;
                        busy <= 1'b1;
                        fault <= 1'b0;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_PLL;
                    end
                end
                S_PLL: begin
                    if (step_ok(pll_pg, use_pgood, cnt_ff)) begin
                        analog_supply_rail_en <= 1'b1;
                        pixel_supply_rail_en <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_ANA;
                    end
                end
                S_ANA: begin
                    if (step_ok(ana_pg, use_pgood, cnt_ff)) begin
                        io_rail_en <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_IO;
                    end
                end
                S_IO: begin
                    if (step_ok(io_pg, use_pgood, cnt_ff)) begin
                        core_rail_en <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_CORE;
                    end
                end
                S_CORE: begin
                    if (step_ok(core_pg, use_pgood, cnt_ff)) begin
                        clk_run_ff <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_RESET;
                    end
                end
                S_RESET: begin
                    // hold reset at least 1 ms
                    if (cnt_done(cnt_ff, RESET_HOLD_CYC)) begin
                        sensor_reset_n <= 1'b1;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_INIT;
                    end
                end
                S_INIT: begin
                    cnt_ff <= cnt_ff;
                    if (ref_rise)
                        cnt_ff <= cnt_ff + 32'd1;
                    if (cnt_ff >= INIT_REF_CYCLES) begin
                        ready_for_config <= 1'b1;
                        state_ff <= S_CONFIG;
                    end
                end
                S_CONFIG: begin
                    if (cfg_done) begin
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_LOCK;
                    end
                end
                S_LOCK: begin
                    // pll lock wait, then stream on request
                    if (cnt_done(cnt_ff, PLL_LOCK_CYC) && stream_req) begin
                        wr_addr <= `RESET_CTRL_ADDR;
                        wr_data <= 16'h0001 << `STREAM_BIT;
                        wr_pend_ff <= 1'b1;
                        state_ff <= S_WR_ON;
                    end else if (power_down_req) begin
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_WAIT_SB;
                    end
                end
                S_WR_ON: begin
                    if (wr_pend_ff && wr_ready) begin
                        streaming <= 1'b1;
                        state_ff <= S_STREAM;
                    end
                end
                S_STREAM: begin
                    if (power_down_req || !stream_req) begin
                        wr_addr <= `RESET_CTRL_ADDR;
                        wr_data <= 16'h0000;
                        wr_pend_ff <= 1'b1;
                        state_ff <= S_WR_OFF;
                    end
                end
                S_WR_OFF: begin
                    if (wr_pend_ff && wr_ready) begin
                        streaming <= 1'b0;
                        cnt_ff <= 32'h0000_0000;
                        state_ff <= S_WAIT_SB;
                    end
                end
                S_WAIT_SB: begin
                    // sensor ends row or frame; wait standby
                    if (sb_done) begin
                        fault <= !standby_s;
                        if (dn_start) begin
                            ready_for_config <= 1'b0;
                            clk_run_ff <= 1'b0;
                            core_rail_en <= 1'b0;
                            cnt_ff <= 32'h0000_0000;
                            state_ff <= S_DN_CORE;
                        end else begin
                            cnt_ff <= 32'h0000_0000;
                            state_ff <= S_LOCK;
                        end
                    end
                end
                S_DN_CORE: begin
                    io_rail_en <= 1'b0;
                    state_ff <= S_DN_IO;
                end
                S_DN_IO: begin
                    analog_supply_rail_en <= 1'b0;
                    pixel_supply_rail_en <= 1'b0;
                    state_ff <= S_DN_ANA;
                end
                S_DN_ANA: begin
                    pll_rail_en <= 1'b0;
                    sensor_reset_n <= 1'b0;
                    cnt_ff <= 32'h0000_0000;
                    state_ff <= S_GAP;
                end
                S_GAP: begin
                    if (cnt_done(cnt_ff, OFF_GAP_CYC))
                        state_ff <= S_OFF;
                end
                default: begin
                    state_ff <= S_OFF;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** testbench/sensor_model.sv ***
// behavioural image sensor: rail power-good, soft standby, stream bit
// assumes the sequencer's pins are wired straight to these ports, except ana_en, which takes the analog and pixel enables ANDed
`timescale 1ns/100ps
`default_nettype none
module sensor_model #(parameter int ROW_CYC = 12) (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic hang,
    input wire logic pll_en,
    input wire logic ana_en,
    input wire logic io_en,
    input wire logic core_en,
    input wire logic rst_n,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    output logic pll_pg,
    output logic ana_pg,
    output logic io_pg,
    output logic core_pg,
    output logic standby,
    output logic wr_ready
);
    logic [15:0] pg_sh = 16'h0000;
    logic stream_bit = 1'b0;
    logic [7:0] row_cnt = 8'h00;
    logic [1:0] wait_cnt = 2'h0;
    // rails settle some cycles after enable and sag likewise after removal
    always @(posedge sys_clk) begin
        pg_sh <= {pg_sh[11:0], core_en, io_en, ana_en, pll_en};
        wait_cnt <= (wr_valid && !wr_ready) ? wait_cnt + 2'h1 : 2'h0;
        // standby ROW_CYC cycles after reset release, lost on core rail loss
        if (!rst_n || !core_en) begin
            stream_bit <= 1'b0;
            row_cnt <= 8'h00;
        end else if (wr_valid && wr_ready && wr_addr == 16'h301A) begin
            stream_bit <= wr_data[2];
            row_cnt <= 8'h00;
        end else if (!stream_bit && row_cnt != ROW_CYC) begin
            row_cnt <= row_cnt + 8'h01;
        end
    end
    assign {core_pg, io_pg, ana_pg, pll_pg} = pg_sh[15:12];
    // hang: a sensor that never reaches standby
    assign standby = !stream_bit && row_cnt == ROW_CYC && !hang;
    assign wr_ready = wr_valid && (!slow || wait_cnt == 2'h3);
endmodule
`default_nettype wire

// *** testbench/seq_checker_asserts.sv ***
// concurrent checks on the power sequencer's pins
// assumes binding to sensor_power_sequencer, counts taken from its parameters
`timescale 1ns/100ps
`default_nettype none
module seq_checker #(
    parameter int RESET_HOLD_CYC = 20,
    parameter int INIT_REF_CYCLES = 10,
    parameter int PLL_LOCK_CYC = 20,
    parameter int OFF_GAP_CYC = 50
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_done,
    input wire logic pll_rail_en,
    input wire logic analog_supply_rail_en,
    input wire logic pixel_supply_rail_en,
    input wire logic io_rail_en,
    input wire logic core_rail_en,
    input wire logic reference_clock_input,
    input wire logic sensor_reset_n,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic ready_for_config
);
    int hold_cnt, ref_cnt, lock_cnt, off_cnt;
    // one cycle of slack on edge counts: pin edge may trail the internal enable
    always @(posedge sys_clk) begin
        hold_cnt <= (core_rail_en && !sensor_reset_n) ? hold_cnt + 1 : 0;
        lock_cnt <= (cfg_done && ready_for_config) ? 0 : lock_cnt + 1;
        off_cnt <= rst ? OFF_GAP_CYC : (pll_rail_en ? 0 : off_cnt + 1);
        if (!sensor_reset_n)
            ref_cnt <= 0;
        else if ($rose(reference_clock_input))
            ref_cnt <= ref_cnt + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_PLL_FIRST: assert property ((analog_supply_rail_en || pixel_supply_rail_en) |->
        pll_rail_en && analog_supply_rail_en == pixel_supply_rail_en)
        else $error("analog or pixel rail without pll rail");
    AST_IO_ORDER: assert property (io_rail_en |-> analog_supply_rail_en)
        else $error("io rail on without analog rail");
    AST_CLK_START: assert property ($rose(reference_clock_input) |-> core_rail_en && io_rail_en)
        else $error("reference clock before rails");
    AST_RESET_HOLD: assert property ($rose(sensor_reset_n) |-> hold_cnt >= RESET_HOLD_CYC)
        else $error("sensor reset released early");
    AST_INIT_WAIT: assert property ($rose(ready_for_config) |-> ref_cnt >= INIT_REF_CYCLES - 1)
        else $error("ready before init count");
    AST_LOCK_WAIT: assert property (wr_valid && wr_data[2] |-> lock_cnt >= PLL_LOCK_CYC - 1)
        else $error("stream write before lock wait");
    AST_STREAM_REG: assert property (wr_valid |-> wr_addr == 16'h301A &&
        (wr_data & 16'hFFFB) == 16'h0000)
        else $error("bad stream control write");
    AST_DOWN_ORDER: assert property (($fell(io_rail_en) |-> !core_rail_en) and
        ($fell(pll_rail_en) |-> !analog_supply_rail_en && !io_rail_en))
        else $error("rails removed out of order");
    AST_OFF_GAP: assert property ($rose(pll_rail_en) |-> off_cnt >= OFF_GAP_CYC)
        else $error("power-up inside off gap");
endmodule
bind sensor_power_sequencer seq_checker #(.RESET_HOLD_CYC(RESET_HOLD_CYC),
    .INIT_REF_CYCLES(INIT_REF_CYCLES), .PLL_LOCK_CYC(PLL_LOCK_CYC), .OFF_GAP_CYC(OFF_GAP_CYC))
    chk_u (.sys_clk(sys_clk), .rst(rst), .cfg_done(cfg_done), .pll_rail_en(pll_rail_en),
    .analog_supply_rail_en(analog_supply_rail_en), .pixel_supply_rail_en(pixel_supply_rail_en),
    .io_rail_en(io_rail_en), .core_rail_en(core_rail_en),
    .reference_clock_input(reference_clock_input), .sensor_reset_n(sensor_reset_n),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .ready_for_config(ready_for_config));
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench: sequencer against a behavioural sensor, random flows
// assumes shortened count parameters; expectations derive from the same values
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int HOLD = 20;
    localparam int INIT = 10;
    localparam int LOCK = 20;
    localparam int GAP = 50;
    localparam int STEP = 500;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic up = 1'b0, down = 1'b0, abort = 1'b0, cfg = 1'b0, sreq = 1'b0;
    logic use_pg = 1'b0, slow = 1'b0, hang = 1'b0, sb_fall = 1'b0, fresh = 1'b1;
    wire pll_pg, ana_pg, io_pg, core_pg, sb, wr_ready, pll_en, ana_en, pix_en, io_en;
    wire core_en, ref_clk, rst_n, wr_valid, ready, streaming, busy, fault;
    wire [15:0] wr_addr, wr_data;
    wire [5:0] rv = {ready, rst_n, core_en, io_en, ana_en, pll_en};
    wire [5:0] ev = {fault, !streaming, !(rv[3:0] != 4'h0 || pix_en), streaming, ready, pll_en};
    logic [5:0] rq = 6'h00;
    int num_errors = 0, tests_run = 0, cyc = 0, seed = 32'h09a7, mode, k;
    int t_up[6], t_dn[6];
    sensor_power_sequencer #(.RESET_HOLD_CYC(HOLD), .INIT_REF_CYCLES(INIT),
        .PLL_LOCK_CYC(LOCK), .OFF_GAP_CYC(GAP), .STANDBY_TIMEOUT_CYC(100)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .power_up_req(up), .power_down_req(down),
        .abort_req(abort), .cfg_done(cfg), .stream_req(sreq), .use_pgood(use_pg),
        .pll_pgood_pin(pll_pg), .analog_pgood_pin(ana_pg), .io_pgood_pin(io_pg),
        .core_pgood_pin(core_pg), .standby_pin(sb), .wr_ready(wr_ready),
        .pll_rail_en(pll_en), .analog_supply_rail_en(ana_en), .pixel_supply_rail_en(pix_en),
        .io_rail_en(io_en), .core_rail_en(core_en), .reference_clock_input(ref_clk),
        .sensor_reset_n(rst_n), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .ready_for_config(ready), .streaming(streaming), .busy(busy), .fault(fault));
    sensor_model model_u (.sys_clk(sys_clk), .slow(slow), .hang(hang), .pll_en(pll_en),
        .ana_en(ana_en & pix_en), .io_en(io_en), .core_en(core_en), .rst_n(rst_n),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .pll_pg(pll_pg),
        .ana_pg(ana_pg), .io_pg(io_pg), .core_pg(core_pg), .standby(sb), .wr_ready(wr_ready));
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        rq <= rv;
        for (int i = 0; i < 6; i++) begin
            if (rv[i] && !rq[i]) t_up[i] <= cyc;
            if (!rv[i] && rq[i]) t_dn[i] <= cyc;
        end
        if (!core_en && rq[3]) sb_fall <= sb;
        if (cyc == 60000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait, sampled on the falling edge where outputs are settled;
    // one more cycle lets the edge stamps of t_up and t_dn land first
    task automatic wait_ev(input int b, input int lim);
        k = 0;
        while (ev[b] !== 1'b1 && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        check(ev[b], 1'b1);
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // flows: 0 power-down, 1 abort, 2 standby never reached, 3 stream stop first
        for (int it = 0; it < 7; it++) begin
            mode = (it < 4) ? it : int'({$random(seed)} % 4);
            @(posedge sys_clk);
            use_pg <= 1'($random(seed));
            slow <= 1'($random(seed));
            up <= 1'b1;
            wait_ev(0, 2 * GAP + 10);
            @(posedge sys_clk);
            up <= 1'b0;
            if (!fresh) check(t_up[0] - t_dn[0] >= GAP, 1'b1);
            fresh = 1'b0;
            check(busy, 1'b1);
            wait_ev(1, 4 * STEP + HOLD + 8 * INIT + 100);
            check(t_up[1] - t_up[0] <= STEP && t_up[2] - t_up[1] <= STEP, 1'b1);
            if (!use_pg) check(t_up[2] - t_up[0], 2 * STEP);
            check(t_up[4] - t_up[3] >= HOLD, 1'b1);
            check(t_up[5] - t_up[4] >= INIT * 4, 1'b1);
            check({rv, pix_en}, 7'h7F);
            @(posedge sys_clk);
            cfg <= 1'b1;
            sreq <= 1'b1;
            @(posedge sys_clk);
            cfg <= 1'b0;
            repeat (LOCK - 2) @(posedge sys_clk);
            @(negedge sys_clk);
            check(streaming, 1'b0);
            wait_ev(2, LOCK + 20);
            check(sb, 1'b0);
            repeat ({$random(seed)} % 8) @(posedge sys_clk);
            @(posedge sys_clk);
            hang <= (mode == 2);
            abort <= (mode == 1);
            sreq <= (mode != 3);
            down <= (mode == 0 || mode == 2);
            if (mode == 3) begin
                wait_ev(4, 200);
                check(rv[3:0], 4'hF);
                @(posedge sys_clk);
                down <= 1'b1;
            end
            wait_ev(mode == 2 ? 5 : 3, 400);
            @(posedge sys_clk);
            abort <= 1'b0;
            down <= 1'b0;
            sreq <= 1'b0;
            hang <= 1'b0;
            @(negedge sys_clk);
            if (mode == 1) begin
                check(t_dn[0] == t_dn[3] && t_dn[1] == t_dn[2] && t_dn[0] == t_dn[1], 1'b1);
            end else if (mode != 2) begin
                check(t_dn[3] <= t_dn[2] && t_dn[2] <= t_dn[1] && t_dn[1] <= t_dn[0], 1'b1);
                check(sb_fall, 1'b1);
            end else begin
                // second reset clears the standby fault
                @(posedge sys_clk);
                rst <= 1'b1;
                repeat (2) @(posedge sys_clk);
                rst <= 1'b0;
                @(negedge sys_clk);
                check({fault, busy, rv}, 8'h00);
                fresh = 1'b1;
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire
